// ==== rtl/memory_access_mode_control.sv ====
// Core memory access steering, checking and boot control
`timescale 1ns/100ps
`default_nettype none
module memory_access_mode_control import mamc_pkg::*; (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Boot strap pins
  input wire logic [1:0] boot_mode_pin,
  // Core access request
  input wire logic acc_valid,
  input wire logic [19:0] acc_addr,
  input wire logic acc_write,
  input wire logic acc_normal,
  input wire logic acc_long_space,
  input wire logic acc_lw,
  input wire logic acc_px,
  input wire logic acc_dreg,
  input wire logic acc_gen,
  input wire logic acc_bidx,
  input wire logic acc_dma,
  input wire logic acc_ioreg,
  input wire logic [63:0] acc_wdata,
  // Internal memory request
  output logic mem_valid,
  output logic mem_write,
  output logic [19:0] mem_addr,
  output logic [1:0] mem_width,
  output logic [63:0] mem_wdata,
  output logic mem_dual,
  input wire logic mem_rvalid,
  input wire logic [63:0] mem_rdata,
  // Register file writes
  output logic [39:0] reg_data,
  output logic reg_wr_primary,
  output logic reg_wr_secondary,
  output logic index_update,
  // Boot DMA
  output logic boot_req,
  output logic [8:0] boot_word,
  input wire logic boot_ready,
  output logic boot_done,
  // Status
  output logic [19:0] vector_base,
  output logic illegal_irq
);
  typedef struct packed {
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [1:0] fill;
    logic [1:0] boot_mode;
    logic strap_taken;
    logic boot_go;
    logic [31:0] system_control_register;
    logic [31:0] first_mode_register;
    logic [31:0] second_mode_register;
    logic [31:0] latch;
    logic [31:0] mask;
    logic [31:0] sticky;
    logic [31:0] prdata;
    logic pready;
    logic err;
    logic mem_valid;
    logic mem_write;
    logic [19:0] mem_addr;
    width_t mem_width;
    logic [63:0] mem_wdata;
    logic mem_dual;
    logic ld_pend;
    fmt_t ld_fmt;
    logic ld_bcast;
    logic [39:0] reg_data;
    logic reg_wr_pri;
    logic reg_wr_sec;
    logic sec_pend;
    logic index_update;
    logic [19:0] vbase;
    logic irq;
  } state_t;

  state_t s_q, s_d;
  boot_link_if lnk();

  boot_loader boot_loader_i (
    .pclk(pclk),
    .presetn(presetn),
    .lnk(lnk.loader)
  );

  logic apb_acc;
  logic apb_wr;
  logic apb_rd;
  logic [1:0] blk;
  logic wide;
  logic lw;
  logic bcast;
  logic io_bad;
  logic unal;
  width_t w;
  fmt_t f;
  logic [63:0] wd;
  logic [31:0] rd;
  logic hit;

  assign lnk.start = s_q.boot_go;
  assign lnk.ready = boot_ready;

  always_comb begin
    s_d = s_q;
    // Strap pins pass three flops; accept once the last two agree
    s_d.sync_a = {s_q.sync_a[1:0], boot_mode_pin[0]};
    s_d.sync_b = {s_q.sync_b[1:0], boot_mode_pin[1]};
    s_d.boot_go = 1'b0;
    // Chain reset value is no pin value; wait until it has filled
    if (s_q.fill != 2'h3) begin
      s_d.fill = s_q.fill + 2'h1;
    end
    if (!s_q.strap_taken && s_q.fill == 2'h3
        && s_q.sync_a[2] == s_q.sync_a[1]
        && s_q.sync_b[2] == s_q.sync_b[1]) begin
      s_d.strap_taken = 1'b1;
      s_d.boot_mode = {s_q.sync_b[2], s_q.sync_a[2]};
      s_d.boot_go = ({s_q.sync_b[2], s_q.sync_a[2]} == BOOT_MEMORY);
    end
    // Vector table base
    if (s_q.system_control_register[VT_SELECT_BIT]) begin
      s_d.vbase = VT_BASE_RAM;
    end else if (s_q.boot_mode == BOOT_NONE) begin
      s_d.vbase = VT_BASE_ROM;
    end else begin
      s_d.vbase = VT_BASE_RAM;
    end

    // Access decode
    blk = acc_addr[18:17];
    wide = s_q.system_control_register[WIDTH_SEL_LSB + 32'(blk)];
    lw = acc_normal && acc_lw;
    bcast = !acc_write && acc_dreg && acc_bidx
      && (acc_gen ? s_q.first_mode_register[BCAST_SECOND_BIT]
                  : s_q.first_mode_register[BCAST_FIRST_BIT]);
    io_bad = acc_ioreg && !acc_dma && s_q.second_mode_register[IO_CHECK_BIT];
    unal = lw && acc_addr[0] && s_q.second_mode_register[UNALIGNED_CHECK_BIT];
    f = FMT_RAW;
    wd = acc_wdata;
    if (lw) begin
      w = W64;
    end else if (acc_px) begin
      w = W48;
    end else if (!acc_normal) begin
      w = acc_long_space ? W64 : W16;
    end else if (wide) begin
      w = W48;
      f = FMT_40;
      wd = {16'h0000, acc_wdata[39:0], 8'h00};
    end else begin
      w = W32;
      f = FMT_32;
      wd = {32'h0000_0000, acc_wdata[39:8]};
    end

    s_d.mem_valid = acc_valid;
    s_d.index_update = 1'b0;
    if (acc_valid) begin
      s_d.mem_write = acc_write;
      s_d.mem_addr = acc_addr;
      s_d.mem_width = w;
      s_d.mem_wdata = wd;
      s_d.mem_dual = s_q.first_mode_register[SEC_ELEM_BIT] && !lw;
      s_d.ld_pend = !acc_write;
      s_d.ld_fmt = f;
      s_d.ld_bcast = bcast;
      s_d.index_update = bcast;
    end

    // Load return and broadcast second write
    s_d.reg_wr_pri = 1'b0;
    s_d.reg_wr_sec = s_q.sec_pend;
    s_d.sec_pend = 1'b0;
    if (mem_rvalid && s_q.ld_pend) begin
      s_d.ld_pend = 1'b0;
      s_d.reg_wr_pri = 1'b1;
      s_d.sec_pend = s_q.ld_bcast;
      unique case (s_q.ld_fmt)
        FMT_32: s_d.reg_data = {mem_rdata[31:0], 8'h00};
        FMT_40: s_d.reg_data = mem_rdata[47:8];
        default: s_d.reg_data = mem_rdata[39:0];
      endcase
    end

    // APB: one wait state, write lands with pready high
    apb_acc = psel && penable;
    apb_wr = apb_acc && pwrite && s_q.pready;
    apb_rd = apb_acc && !pwrite && !s_q.pready;
    s_d.pready = apb_acc && !s_q.pready;
    hit = 1'b1;
    rd = 32'h0000_0000;
    unique case (paddr)
      OFS_SYSTEM_CONTROL: rd = s_q.system_control_register;
      OFS_FIRST_MODE: rd = s_q.first_mode_register;
      OFS_SECOND_MODE: rd = s_q.second_mode_register;
      OFS_INTERRUPT_LATCH: rd = s_q.latch;
      OFS_INTERRUPT_MASK: rd = s_q.mask;
      OFS_STICKY_STATUS: rd = s_q.sticky;
      OFS_BOOT_STATUS: rd = {s_q.vbase, 8'h00, lnk.busy, lnk.done,
                             s_q.boot_mode};
      default: hit = 1'b0;
    endcase
    s_d.err = apb_acc && !s_q.pready && !hit;
    if (apb_rd) begin
      s_d.prdata = rd;
    end
    if (apb_wr) begin
      unique case (paddr)
        OFS_SYSTEM_CONTROL: s_d.system_control_register = pwdata & SYSTEM_CONTROL_REGISTER_MASK;
        OFS_FIRST_MODE: s_d.first_mode_register = pwdata & FIRST_MODE_REGISTER_MASK;
        OFS_SECOND_MODE: s_d.second_mode_register = pwdata & SECOND_MODE_REGISTER_MASK;
        OFS_INTERRUPT_LATCH: s_d.latch = s_q.latch & ~pwdata;
        OFS_INTERRUPT_MASK: s_d.mask = pwdata & FLAG_MASK;
        OFS_STICKY_STATUS: s_d.sticky = s_q.sticky & ~pwdata;
        default: ;
      endcase
    end

    // Illegal access flags; a set beats a same-cycle clear
    if (acc_valid && io_bad) begin
      s_d.latch[ILLEGAL_INPUT_BIT] = 1'b1;
      s_d.sticky[STKY_IO_BIT] = 1'b1;
    end
    if (acc_valid && unal) begin
      s_d.sticky[STKY_UNALIGNED_BIT] = 1'b1;
      if (s_q.mask[ILLEGAL_INPUT_BIT]) begin
        s_d.latch[ILLEGAL_INPUT_BIT] = 1'b1;
      end
    end
    s_d.irq = s_d.latch[ILLEGAL_INPUT_BIT] && s_d.mask[ILLEGAL_INPUT_BIT];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.vbase <= VT_BASE_RAM;
      s_q.mem_width <= W16;
      s_q.ld_fmt <= FMT_RAW;
      s_q.system_control_register <= REG_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.err;
  assign mem_valid = s_q.mem_valid;
  assign mem_write = s_q.mem_write;
  assign mem_addr = s_q.mem_addr;
  assign mem_width = s_q.mem_width;
  assign mem_wdata = s_q.mem_wdata;
  assign mem_dual = s_q.mem_dual;
  assign reg_data = s_q.reg_data;
  assign reg_wr_primary = s_q.reg_wr_pri;
  assign reg_wr_secondary = s_q.reg_wr_sec;
  assign index_update = s_q.index_update;
  assign boot_req = lnk.req;
  assign boot_word = lnk.addr;
  assign boot_done = lnk.done;
  assign vector_base = s_q.vbase;
  assign illegal_irq = s_q.irq;

  // Checks
  a_vt_forced: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.system_control_register[VT_SELECT_BIT] |=> vector_base == VT_BASE_RAM)
    else $error("vector base not forced to RAM");
  a_vt_noboot: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.strap_taken && s_q.boot_mode == BOOT_NONE
    && !s_q.system_control_register[VT_SELECT_BIT] |=> vector_base == VT_BASE_ROM)
    else $error("no-boot vector base wrong");
  a_width_narrow: assert property (@(posedge pclk) disable iff (!presetn)
    acc_valid && acc_write && acc_normal && !acc_lw && !acc_px && !wide
    |=> mem_width == W32 && mem_wdata[31:0] == $past(acc_wdata[39:8]))
    else $error("32-bit store not truncated");
  a_width_wide: assert property (@(posedge pclk) disable iff (!presetn)
    acc_valid && acc_normal && !acc_lw && !acc_px && wide
    |=> mem_width == W48)
    else $error("wide block not 48-bit");
  a_px_width: assert property (@(posedge pclk) disable iff (!presetn)
    acc_valid && acc_px && !(acc_normal && acc_lw) |=> mem_width == W48)
    else $error("exchange register not 48-bit");
  a_lw_priority: assert property (@(posedge pclk) disable iff (!presetn)
    acc_valid && acc_normal && acc_lw |=> mem_width == W64 && !mem_dual)
    else $error("forced long word lost priority");
  a_dual_mode: assert property (@(posedge pclk) disable iff (!presetn)
    acc_valid && !acc_lw && s_q.first_mode_register[SEC_ELEM_BIT] |=> mem_dual)
    else $error("dual transfer missing");
  a_bcast_order: assert property (@(posedge pclk) disable iff (!presetn)
    reg_wr_primary && $past(s_q.ld_bcast) |=> reg_wr_secondary
    ##1 !reg_wr_secondary)
    else $error("broadcast second write misplaced");
  a_io_flag: assert property (@(posedge pclk) disable iff (!presetn)
    acc_valid && acc_ioreg && !acc_dma && s_q.second_mode_register[IO_CHECK_BIT]
    |=> s_q.sticky[STKY_IO_BIT] && s_q.latch[ILLEGAL_INPUT_BIT])
    else $error("illegal I/O access not flagged");
  a_dma_exempt: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s_q.sticky[STKY_IO_BIT]) |-> $past(acc_valid && !acc_dma))
    else $error("DMA access raised flag");
  a_unal_mask: assert property (@(posedge pclk) disable iff (!presetn)
    acc_valid && unal && !s_q.mask[ILLEGAL_INPUT_BIT]
    && !s_q.latch[ILLEGAL_INPUT_BIT] && !io_bad
    |=> s_q.sticky[STKY_UNALIGNED_BIT] && !s_q.latch[ILLEGAL_INPUT_BIT])
    else $error("masked unaligned access latched");
endmodule // memory_access_mode_control
`default_nettype wire

// ==== rtl/mamc_pkg.sv ====
// Shared constants and types for the memory access mode controller
package mamc_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_SYSTEM_CONTROL = 12'h000;
  localparam logic [11:0] OFS_FIRST_MODE = 12'h004;
  localparam logic [11:0] OFS_SECOND_MODE = 12'h008;
  localparam logic [11:0] OFS_INTERRUPT_LATCH = 12'h00C;
  localparam logic [11:0] OFS_INTERRUPT_MASK = 12'h010;
  localparam logic [11:0] OFS_STICKY_STATUS = 12'h014;
  localparam logic [11:0] OFS_BOOT_STATUS = 12'h018;
  // Field positions
  localparam int VT_SELECT_BIT = 2;
  localparam int WIDTH_SEL_LSB = 9;
  localparam int SEC_ELEM_BIT = 0;
  localparam int BCAST_FIRST_BIT = 1;
  localparam int BCAST_SECOND_BIT = 2;
  localparam int IO_CHECK_BIT = 0;
  localparam int UNALIGNED_CHECK_BIT = 21;
  localparam int ILLEGAL_INPUT_BIT = 0;
  localparam int STKY_IO_BIT = 0;
  localparam int STKY_UNALIGNED_BIT = 1;
  localparam int STAT_DONE_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_BASE_LSB = 12;
  // Writable masks and reset values
  localparam logic [31:0] SYSTEM_CONTROL_REGISTER_MASK = 32'h0000_1E04;
  localparam logic [31:0] FIRST_MODE_REGISTER_MASK = 32'h0000_0007;
  localparam logic [31:0] SECOND_MODE_REGISTER_MASK = 32'h0020_0001;
  localparam logic [31:0] FLAG_MASK = 32'h0000_0001;
  localparam logic [31:0] STKY_MASK = 32'h0000_0003;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // Vector table bases
  localparam logic [19:0] VT_BASE_RAM = 20'h9_0000;
  localparam logic [19:0] VT_BASE_ROM = 20'h8_0000;
  // Boot source codes on the strap pins
  localparam logic [1:0] BOOT_NONE = 2'h0;
  localparam logic [1:0] BOOT_MEMORY = 2'h1;
  // Boot load size
  localparam int BOOT_INSTR = 256;
  localparam int BOOT_WORDS = BOOT_INSTR * 3 / 2;
  localparam logic [8:0] BOOT_LAST = 9'(BOOT_WORDS - 1);
  // Memory access widths
  typedef enum logic [1:0] {
    W16 = 2'h0, W32 = 2'h1, W48 = 2'h2, W64 = 2'h3
  } width_t;
  // Load formatting of returned memory data
  typedef enum logic [1:0] {
    FMT_RAW = 2'h0, FMT_32 = 2'h1, FMT_40 = 2'h2
  } fmt_t;
  // Boot loader states, Gray along the path
  typedef enum logic [1:0] {
    BL_IDLE = 2'h0, BL_RUN = 2'h1, BL_DONE = 2'h3
  } boot_st_t;
endpackage

// ==== rtl/boot_link_if.sv ====
// Link between the controller and its boot loader
`timescale 1ns/100ps
`default_nettype none
interface boot_link_if;
  logic start;
  logic done;
  logic busy;
  logic req;
  logic ready;
  logic [8:0] addr;
  modport loader(input start, ready, output done, busy, req, addr);
  modport ctrl(output start, ready, input done, busy, req, addr);
endinterface
`default_nettype wire

// ==== rtl/boot_loader.sv ====
// Fetches the first boot words into internal memory
`timescale 1ns/100ps
`default_nettype none
module boot_loader import mamc_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link to controller
  boot_link_if.loader lnk
);
  typedef struct packed {
    boot_st_t st;
    logic [8:0] addr;
    logic req;
  } bl_state_t;

  bl_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    unique case (s_q.st)
      BL_IDLE: begin
        if (lnk.start) begin
          s_d.st = BL_RUN;
          s_d.req = 1'b1;
          s_d.addr = 9'h000;
        end
      end
      BL_RUN: begin
        // Word moves when memory side accepts it
        if (lnk.ready) begin
          if (s_q.addr == BOOT_LAST) begin
            s_d.st = BL_DONE;
            s_d.req = 1'b0;
          end else begin
            s_d.addr = s_q.addr + 9'h001;
          end
        end
      end
      BL_DONE: begin
        s_d.req = 1'b0;
      end
      default: begin
        s_d.st = BL_IDLE;
        s_d.req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{st: BL_IDLE, addr: 9'h000, req: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign lnk.req = s_q.req;
  assign lnk.addr = s_q.addr;
  assign lnk.busy = (s_q.st == BL_RUN);
  assign lnk.done = (s_q.st == BL_DONE);
endmodule // boot_loader
`default_nettype wire

// ==== bench/sram_model.sv ====
// Internal memory and boot source stand-in for the controller
`timescale 1ns/100ps
`default_nettype none
module sram_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Memory side
  input wire logic mem_valid,
  input wire logic mem_write,
  input wire logic [19:0] mem_addr,
  output logic mem_rvalid,
  output logic [63:0] mem_rdata,
  // Boot side
  input wire logic boot_req,
  output logic boot_ready
);
  logic [1:0] cnt_q;
  logic [19:0] a_q;
  logic slow_q;
  logic tick_q;
  // Boot source accepts every other cycle
  assign boot_ready = boot_req & tick_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 2'h0;
      a_q <= 20'h0;
      slow_q <= 1'h0;
      tick_q <= 1'h0;
      mem_rvalid <= 1'h0;
      mem_rdata <= 64'h0;
    end else begin
      tick_q <= ~tick_q;
      mem_rvalid <= 1'h0;
      // Idle data keeps changing
      mem_rdata <= ~mem_rdata;
      if (mem_valid && !mem_write) begin
        a_q <= mem_addr;
        // Alternate prompt and slow answers
        cnt_q <= slow_q ? 2'h3 : 2'h1;
        slow_q <= ~slow_q;
      end else if (cnt_q != 2'h0) begin
        cnt_q <= cnt_q - 2'h1;
        if (cnt_q == 2'h1) begin
          mem_rvalid <= 1'h1;
          mem_rdata <= {4{a_q[15:0]}} ^ 64'h0123_4567_89AB_CDEF;
        end
      end
    end
  end
endmodule // sram_model
`default_nettype wire

// ==== bench/memory_access_mode_control_tb.sv ====
// Self-checking bench for the memory access mode controller
`timescale 1ns/100ps
`default_nettype none
module memory_access_mode_control_tb import mamc_pkg::*; ;
  localparam logic [9:0] WR = 10'h200, NRM = 10'h100, LSP = 10'h080;
  localparam logic [9:0] FLW = 10'h040, XCH = 10'h020, DRG = 10'h010;
  localparam logic [9:0] GEN = 10'h008, BIX = 10'h004, DMA = 10'h002;
  localparam logic [9:0] IO = 10'h001;
  localparam logic [63:0] WD = 64'hFEDC_BA12_3456_789A;
  localparam logic [63:0] M32 = 64'hFFFF_FFFF, D32 = 64'h1234_5678;
  localparam logic [63:0] M48 = 64'hFFFF_FFFF_FFFF, ALL = '1;
  typedef struct packed {
    logic [3:0] ws;
    logic [19:0] a;
    logic [9:0] f;
    logic [1:0] w;
    logic [63:0] m;
    logic [63:0] d;
  } row_t;
  localparam row_t ROWS [8] = '{
    '{4'h0, 20'h80010, WR | NRM, W32, M32, D32},
    '{4'h2, 20'hA0010, WR | NRM, W48, M48, 64'h1234_5678_9A00},
    '{4'hD, 20'hA0010, WR | NRM, W32, M32, D32},
    '{4'h0, 20'h80010, WR | NRM | XCH, W48, M48, WD & M48},
    '{4'h0, 20'h80010, WR | NRM | XCH | FLW, W64, ALL, WD},
    '{4'hF, 20'h80012, WR | NRM | FLW, W64, ALL, WD},
    '{4'h0, 20'h40010, WR | FLW, W16, 64'h0, 64'h0},
    '{4'h0, 20'h40010, WR | LSP, W64, 64'h0, 64'h0}};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [1:0] boot_mode_pin, mem_width;
  logic acc_valid, acc_write, acc_normal, acc_long_space, acc_lw, acc_px;
  logic acc_dreg, acc_gen, acc_bidx, acc_dma, acc_ioreg;
  logic [19:0] acc_addr, mem_addr, vector_base;
  logic [63:0] mem_wdata, mem_rdata, p;
  logic mem_valid, mem_write, mem_dual, mem_rvalid;
  logic [39:0] reg_data, pd;
  logic reg_wr_primary, reg_wr_secondary, index_update, iu, s0, sec;
  logic boot_req, boot_ready, boot_done, illegal_irq;
  logic [8:0] boot_word;
  int bad_count, samples_checked, n;
  memory_access_mode_control memory_access_mode_control_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .boot_mode_pin, .acc_valid, .acc_addr, .acc_write,
    .acc_normal, .acc_long_space, .acc_lw, .acc_px, .acc_dreg, .acc_gen,
    .acc_bidx, .acc_dma, .acc_ioreg, .acc_wdata(WD), .mem_valid,
    .mem_write, .mem_addr, .mem_width, .mem_wdata, .mem_dual, .mem_rvalid,
    .mem_rdata, .reg_data, .reg_wr_primary, .reg_wr_secondary,
    .index_update, .boot_req, .boot_word, .boot_ready, .boot_done,
    .vector_base, .illegal_irq);
  sram_model sram_model_i (.pclk, .presetn, .mem_valid, .mem_write,
    .mem_addr, .mem_rvalid, .mem_rdata, .boot_req, .boot_ready);
  always #5 pclk = ~pclk;
  // Words taken by the boot source
  always @(posedge pclk) begin
    if (boot_req === 1'h1 && boot_ready === 1'h1) n++;
  end
  task automatic chk(input string nm, input logic [63:0] s, e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic stall();
    bad_count++;
    $display("CHECK FAILED wait expected answer seen timeout");
    report_and_stop();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (i == 20) stall();
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic acc(input logic [19:0] a, input logic [9:0] f);
    @(posedge pclk);
    acc_valid <= 1'h1;
    acc_addr <= a;
    {acc_write, acc_normal, acc_long_space, acc_lw, acc_px, acc_dreg,
      acc_gen, acc_bidx, acc_dma, acc_ioreg} <= f;
    @(posedge pclk);
    acc_valid <= 1'h0;
    #1;
    iu = index_update;
  endtask
  task automatic ld(input logic [9:0] f);
    int i;
    acc(20'h80010, f);
    for (i = 0; i < 20 && reg_wr_primary !== 1'h1; i++) begin
      @(posedge pclk);
      #1;
    end
    if (i == 20) stall();
    pd = reg_data;
    s0 = reg_wr_secondary;
    @(posedge pclk);
    #1;
    sec = reg_wr_secondary;
  endtask
  task automatic do_reset(input logic [1:0] m);
    @(posedge pclk);
    presetn <= 1'h0;
    boot_mode_pin <= m;
    repeat (5) @(posedge pclk);
    n = 0;
    presetn <= 1'h1;
    repeat (8) @(posedge pclk);
    #1;
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {boot_mode_pin, acc_valid, acc_addr} = '0;
    {acc_write, acc_normal, acc_long_space, acc_lw, acc_px, acc_dreg,
      acc_gen, acc_bidx, acc_dma, acc_ioreg} = '0;
    bad_count = 0;
    samples_checked = 0;
    p = {4{16'h0010}} ^ 64'h0123_4567_89AB_CDEF;
    do_reset(BOOT_NONE);
    chk("base no boot", vector_base, VT_BASE_ROM);
    chk("no boot fetch", boot_req, 1'h0);
    for (int k = 0; k < 8; k++) begin
      apb(1'h1, OFS_SYSTEM_CONTROL, 32'(ROWS[k].ws) << 9);
      acc(ROWS[k].a, ROWS[k].f);
      chk("mem_valid", mem_valid, 1'h1);
      chk("mem_addr", mem_addr, ROWS[k].a);
      chk("mem_write", mem_write, ROWS[k].f[9]);
      chk("mem_width", mem_width, ROWS[k].w);
      chk("mem_wdata", mem_wdata & ROWS[k].m, ROWS[k].d);
    end
    apb(1'h1, OFS_SYSTEM_CONTROL, 32'h4);
    apb(1'h0, OFS_SYSTEM_CONTROL, 32'h0);
    chk("vector select", rdat, 32'h4);
    chk("base forced", vector_base, VT_BASE_RAM);
    apb(1'h0, 12'h01C, 32'h0);
    chk("unmapped", rerr, 1'h1);
    ld(NRM);
    chk("load 32", pd, {p[31:0], 8'h00});
    apb(1'h1, OFS_SYSTEM_CONTROL, 32'h204);
    ld(NRM);
    chk("load 48", pd, p[47:8]);
    apb(1'h1, OFS_SYSTEM_CONTROL, 32'h4);
    apb(1'h1, OFS_FIRST_MODE, 32'h1);
    acc(20'h80010, WR | NRM);
    chk("dual on", mem_dual, 1'h1);
    acc(20'h80010, WR | NRM | FLW);
    chk("dual forced", mem_dual, 1'h0);
    apb(1'h1, OFS_FIRST_MODE, 32'h0);
    acc(20'h80010, WR | NRM);
    chk("dual off", mem_dual, 1'h0);
    for (int g = 0; g < 2; g++) begin
      apb(1'h1, OFS_FIRST_MODE, (g == 1) ? 32'h5 : 32'h2);
      ld(NRM | DRG | BIX | ((g == 1) ? GEN : 10'h0));
      chk("bcast index", iu, 1'h1);
      chk("bcast order", s0, 1'h0);
      chk("bcast both", sec, 1'h1);
      chk("bcast data", pd, {p[31:0], 8'h00});
      ld(NRM | DRG | BIX | ((g == 1) ? 10'h0 : GEN));
      chk("other gen", sec, 1'h0);
      ld(NRM | BIX | ((g == 1) ? GEN : 10'h0));
      chk("not dreg", sec, 1'h0);
    end
    apb(1'h1, OFS_FIRST_MODE, 32'h0);
    apb(1'h1, OFS_SECOND_MODE, 32'h1);
    acc(20'h80010, WR | NRM | IO | DMA);
    apb(1'h0, OFS_INTERRUPT_LATCH, 32'h0);
    chk("dma io", rdat, 32'h0);
    acc(20'h80010, WR | NRM | IO);
    acc(20'h80010, WR | NRM);
    apb(1'h0, OFS_INTERRUPT_LATCH, 32'h0);
    chk("core io", rdat, 32'h1);
    apb(1'h0, OFS_STICKY_STATUS, 32'h0);
    chk("sticky io", rdat, 32'h1);
    apb(1'h1, OFS_STICKY_STATUS, 32'h1);
    apb(1'h1, OFS_INTERRUPT_LATCH, 32'h1);
    apb(1'h0, OFS_STICKY_STATUS, 32'h0);
    chk("sticky clear", rdat, 32'h0);
    apb(1'h1, OFS_SECOND_MODE, 32'h0020_0000);
    acc(20'h80012, WR | NRM | FLW);
    apb(1'h0, OFS_STICKY_STATUS, 32'h0);
    chk("even long", rdat, 32'h0);
    acc(20'h80013, WR | NRM | FLW);
    apb(1'h0, OFS_STICKY_STATUS, 32'h0);
    chk("odd long", rdat, 32'h2);
    apb(1'h0, OFS_INTERRUPT_LATCH, 32'h0);
    chk("masked", rdat, 32'h0);
    apb(1'h1, OFS_INTERRUPT_MASK, 32'h1);
    acc(20'h80013, WR | NRM | FLW);
    apb(1'h0, OFS_INTERRUPT_LATCH, 32'h0);
    chk("unmasked", rdat, 32'h1);
    chk("irq", illegal_irq, 1'h1);
    do_reset(BOOT_MEMORY);
    for (int i = 0; i < 2000 && boot_done !== 1'h1; i++) @(posedge pclk);
    #1;
    if (boot_done !== 1'h1) stall();
    chk("boot words", n, 384);
    chk("boot last", boot_word, BOOT_LAST);
    chk("boot stop", boot_req, 1'h0);
    apb(1'h0, OFS_BOOT_STATUS, 32'h0);
    chk("status", rdat, {VT_BASE_RAM, 8'h00, 1'h0, 1'h1, BOOT_MEMORY});
    chk("base boot", vector_base, VT_BASE_RAM);
    do_reset(2'h2);
    chk("base external", vector_base, VT_BASE_RAM);
    report_and_stop();
  end
endmodule // memory_access_mode_control_tb
`default_nettype wire
